// file: iolt_ext_equip.sv
// external equipment on the control i/o pin
// assumes drv_en and drv_val come from the bench on hclk
`timescale 1ns/1ps
module iolt_ext_equip (
   input wire hclk,
   input wire line_out,
   input wire line_oe,
   input wire drv_en,
   input wire drv_val,
   output wire line_in
);
   reg last = 1'h0;
   // a pin nobody drives toggles, so a design that reads it cannot pass by luck
   assign line_in = line_oe ? line_out : (drv_en ? drv_val : ~last);
   always @(posedge hclk)
      last <= line_in;
endmodule // iolt_ext_equip

// file: iolt_line.v
// single camera control i/o line: source mux, inversion, debounce filter and line pulse timer
// assumes an ahb-lite master on hclk; frame and exposure activity come from logic on hclk
//
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "iolt_regs.vh"

module iolt_line #(
   parameter CYC_PER_US = `IOLT_CYC_PER_US,
   parameter US_W = 26
)
(
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   input wire frame_active,
   input wire exposure_active,
   input wire line_in,
   output wire line_out,
   output wire line_oe,
   output wire line_level
);

   localparam ST_IDLE = 3'b001;
   localparam ST_DELAY = 3'b010;
   localparam ST_PULSE = 3'b100;

   reg [31:0] ctrl_reg;
   reg user_reg;
   reg [19:0] debounce_reg;
   reg [31:0] trig_reg;
   reg [US_W-1:0] duration_reg;
   reg [US_W-1:0] delay_reg;
   reg wr_pend_reg;
   reg rd_pend_reg;
   reg [11:0] addr_reg;
   reg [7:0] us_cnt_reg;
   reg in_meta_reg;
   reg in_sync_reg;
   reg in_level_reg;
   reg [19:0] db_cnt_reg;
   reg trig_prev_reg;
   reg [2:0] state_reg;
   reg [US_W-1:0] tm_cnt_reg;
   reg timer_reg;
   reg line_reg;
   reg oe_reg;

   wire [4:0] line_src = ctrl_reg[`IOLT_CTRL_SRC_MSB:`IOLT_CTRL_SRC_LSB];
   wire [4:0] trig_src = trig_reg[`IOLT_TRIG_SRC_MSB:`IOLT_TRIG_SRC_LSB];
   wire [1:0] trig_act = trig_reg[`IOLT_TRIG_ACT_MSB:`IOLT_TRIG_ACT_LSB];
   wire [31:0] us_last = CYC_PER_US - 1;
   wire us_tick = ({24'h00_0000, us_cnt_reg} == us_last);
   wire addr_phase = hsel & hready & htrans[1];
   wire [11:0] addr_off = {haddr[11:2], 2'b00};

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // ahb-lite slave: zero wait states, writes land in the data phase
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg <= 12'h000;
      end
      else if (hready)
      begin
         wr_pend_reg <= addr_phase & hwrite;
         rd_pend_reg <= addr_phase & ~hwrite;
         addr_reg <= addr_off;
      end
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ctrl_reg <= `IOLT_CTRL_RESET;
         user_reg <= `IOLT_USER_RESET;
         debounce_reg <= `IOLT_DEBOUNCE_RESET;
         trig_reg <= `IOLT_TRIG_RESET;
         duration_reg <= `IOLT_DURATION_RESET;
         delay_reg <= `IOLT_DELAY_RESET;
      end
      else if (wr_pend_reg)
      begin
         case (addr_reg)
            `IOLT_CTRL_OFFSET: ctrl_reg <= hwdata & 32'h0000_1F03;
            `IOLT_USER_OFFSET: user_reg <= hwdata[0];
            // out-of-range values clamp to the documented ceiling
            `IOLT_DEBOUNCE_OFFSET: debounce_reg <= (hwdata > `IOLT_DEBOUNCE_MAX_US) ?
               20'hF_4240 : hwdata[19:0];
            `IOLT_TRIG_OFFSET: trig_reg <= hwdata & 32'h0000_031F;
            `IOLT_DURATION_OFFSET: duration_reg <= (hwdata == 32'h0000_0000) ? 26'h000_0001 :
               (hwdata > `IOLT_TIMER_MAX_US) ? 26'h393_8700 : hwdata[US_W-1:0];
            `IOLT_DELAY_OFFSET: delay_reg <= (hwdata > `IOLT_TIMER_MAX_US) ?
               26'h393_8700 : hwdata[US_W-1:0];
            default: ;
         endcase
      end
   end

   always @*
   begin
      hrdata = 32'h0000_0000;
      if (rd_pend_reg)
      begin
         case (addr_reg)
            `IOLT_CTRL_OFFSET: hrdata = ctrl_reg;
            `IOLT_USER_OFFSET: hrdata = {31'h0000_0000, user_reg};
            `IOLT_DEBOUNCE_OFFSET: hrdata = {12'h000, debounce_reg};
            `IOLT_TRIG_OFFSET: hrdata = trig_reg;
            `IOLT_DURATION_OFFSET: hrdata = {6'h00, duration_reg};
            `IOLT_DELAY_OFFSET: hrdata = {6'h00, delay_reg};
            `IOLT_STATUS_OFFSET: hrdata = {28'h000_0000, state_reg != ST_IDLE, timer_reg, line_reg, in_level_reg};
            default: hrdata = 32'h0000_0000;
         endcase
      end
   end

   // free-running microsecond tick shared by debounce and timer
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         us_cnt_reg <= 8'h00;
      else if (us_tick)
         us_cnt_reg <= 8'h00;
      else
         us_cnt_reg <= us_cnt_reg + 8'h01;
   end

   // debounce: the pin passes two flops, then must hold a new level for the programmed time.
   // resolution is one tick, so the accept latency sits between time and time plus one microsecond
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         in_meta_reg <= 1'b0;
         in_sync_reg <= 1'b0;
         in_level_reg <= 1'b0;
         db_cnt_reg <= 20'h0_0000;
      end
      else
      begin
         in_meta_reg <= line_in;
         in_sync_reg <= in_meta_reg;
         if (line_src == `IOLT_SRC_OFF || ctrl_reg[`IOLT_CTRL_DIR_BIT])
            db_cnt_reg <= 20'h0_0000;
         else if (in_sync_reg == in_level_reg)
            db_cnt_reg <= 20'h0_0000;
         // strictly greater: the first tick may come at once, so a glitch just short of the time must not pass
         else if (debounce_reg == 20'h0_0000 || db_cnt_reg > debounce_reg)
         begin
            in_level_reg <= in_sync_reg;
            db_cnt_reg <= 20'h0_0000;
         end
         else if (us_tick)
            db_cnt_reg <= db_cnt_reg + 20'h0_0001;
      end
   end

   // line pulse timer
   reg trig_sig;
   always @*
   begin
      case (trig_src)
         `IOLT_SRC_FRAME: trig_sig = frame_active;
         `IOLT_SRC_EXPOSURE: trig_sig = exposure_active;
         default: trig_sig = 1'b0;
      endcase
   end

   wire trig_on = (trig_src == `IOLT_SRC_FRAME) || (trig_src == `IOLT_SRC_EXPOSURE);
   wire level_mode = trig_act[1];
   wire level_true = (trig_act == `IOLT_ACT_HIGH) ? trig_sig : ~trig_sig;
   wire edge_hit = (trig_act == `IOLT_ACT_RISE) ? (trig_sig & ~trig_prev_reg) :
      (~trig_sig & trig_prev_reg);
   wire start = trig_on & (level_mode ? level_true : edge_hit);

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         trig_prev_reg <= 1'b0;
         state_reg <= ST_IDLE;
         tm_cnt_reg <= {US_W{1'b0}};
         timer_reg <= 1'b0;
      end
      else
      begin
         trig_prev_reg <= trig_sig;
         case (state_reg)
            ST_IDLE:
            begin
               timer_reg <= 1'b0;
               tm_cnt_reg <= {US_W{1'b0}};
               if (start)
               begin
                  if (delay_reg == {US_W{1'b0}})
                  begin
                     state_reg <= ST_PULSE;
                     timer_reg <= 1'b1;
                  end
                  else
                     state_reg <= ST_DELAY;
               end
            end
            ST_DELAY:
            begin
               if (!trig_on || (level_mode && !level_true))
                  state_reg <= ST_IDLE;
               else if (us_tick)
               begin
                  if (tm_cnt_reg + 26'h000_0001 >= delay_reg)
                  begin
                     state_reg <= ST_PULSE;
                     timer_reg <= 1'b1;
                     tm_cnt_reg <= {US_W{1'b0}};
                  end
                  else
                     tm_cnt_reg <= tm_cnt_reg + 26'h000_0001;
               end
            end
            ST_PULSE:
            begin
               if (!trig_on)
               begin
                  state_reg <= ST_IDLE;
                  timer_reg <= 1'b0;
               end
               else if (level_mode)
               begin
                  if (!level_true)
                  begin
                     state_reg <= ST_IDLE;
                     timer_reg <= 1'b0;
                  end
               end
               else if (us_tick)
               begin
                  if (tm_cnt_reg + 26'h000_0001 >= duration_reg)
                  begin
                     state_reg <= ST_IDLE;
                     timer_reg <= 1'b0;
                  end
                  else
                     tm_cnt_reg <= tm_cnt_reg + 26'h000_0001;
               end
            end
            default:
            begin
               state_reg <= ST_IDLE;
               timer_reg <= 1'b0;
            end
         endcase
      end
   end

   // source mux then inversion, registered so the pin never glitches
   reg src_val;
   always @*
   begin
      case (line_src)
         `IOLT_SRC_FRAME: src_val = frame_active;
         `IOLT_SRC_EXPOSURE: src_val = exposure_active;
         `IOLT_SRC_USER: src_val = user_reg;
         `IOLT_SRC_TIMER: src_val = timer_reg;
         default: src_val = 1'b0;
      endcase
   end

   wire src_valid = (line_src == `IOLT_SRC_FRAME) || (line_src == `IOLT_SRC_EXPOSURE) ||
      (line_src == `IOLT_SRC_USER) || (line_src == `IOLT_SRC_TIMER);

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         line_reg <= 1'b0;
         oe_reg <= 1'b0;
      end
      else
      begin
         line_reg <= src_val ^ ctrl_reg[`IOLT_CTRL_INV_BIT];
         oe_reg <= ctrl_reg[`IOLT_CTRL_DIR_BIT] & src_valid;
      end
   end

   assign line_out = line_reg;
   assign line_oe = oe_reg;
   assign line_level = in_level_reg;

endmodule // iolt_line

// file: iolt_line_props.sv
// assertions on the control i/o line ports, with shadows of ctrl, user and debounce writes
// assumes hready is hreadyout and every write is a whole word
`timescale 1ns/1ps
`include "iolt_regs.vh"
module iolt_line_props (
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   input wire hreadyout,
   input wire hresp,
   input wire [31:0] hrdata,
   input wire frame_active,
   input wire exposure_active,
   input wire line_in,
   input wire line_out,
   input wire line_oe,
   input wire line_level
);
   reg ap_wr, ap_rd;
   reg [11:0] ap_a;
   reg [31:0] ctrl_q, ctrl_d, deb_q;
   reg user_q, user_d;
   wire [4:0] src_d = ctrl_d[12:8];
   wire hold_d = ctrl_d[0] | (src_d == `IOLT_SRC_OFF);
   wire src_on = (src_d == `IOLT_SRC_FRAME) | (src_d == `IOLT_SRC_EXPOSURE) | (src_d == `IOLT_SRC_USER)
      | (src_d == `IOLT_SRC_TIMER);
   // ctrl_d lags the design's register by one edge, matching the registered pin outputs
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         {ap_wr, ap_rd, ap_a, ctrl_q, ctrl_d, deb_q, user_q, user_d} <= 0;
      end
      else
      begin
         ap_wr <= hsel & hready & htrans[1] & hwrite;
         ap_rd <= hsel & hready & htrans[1] & !hwrite;
         ap_a <= {haddr[11:2], 2'h0};
         if (ap_wr && ap_a == `IOLT_CTRL_OFFSET)
            ctrl_q <= hwdata;
         if (ap_wr && ap_a == `IOLT_USER_OFFSET)
            user_q <= hwdata[0];
         if (ap_wr && ap_a == `IOLT_DEBOUNCE_OFFSET)
            deb_q <= hwdata;
         ctrl_d <= ctrl_q;
         user_d <= user_q;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_oe_follows_dir: assert property (line_oe == (ctrl_d[0] & src_on))
      else $error("line_oe disagrees with direction and source");
   a_off_no_drive: assert property ((src_d == `IOLT_SRC_OFF) |-> !line_oe)
      else $error("line driven with source off");
   a_out_frame: assert property ((src_d == `IOLT_SRC_FRAME) |-> line_out == ($past(frame_active) ^ ctrl_d[1]))
      else $error("line_out does not follow frame activity");
   a_out_exposure: assert property ((src_d == `IOLT_SRC_EXPOSURE) |-> line_out == ($past(exposure_active) ^ ctrl_d[1]))
      else $error("line_out does not follow exposure activity");
   a_out_user_inv: assert property ((src_d == `IOLT_SRC_USER) |-> line_out == (user_d ^ ctrl_d[1]))
      else $error("line_out does not follow the user bit");
   a_level_held: assert property (hold_d && $past(hold_d) |-> $stable(line_level))
      else $error("line_level moved while input is disabled");
   a_level_stable: assert property ((deb_q >= 2) && $changed(line_level) |-> $past(line_in, 4) == line_level)
      else $error("line_level took an unstable input");
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready okay");
   a_rdata_idle: assert property (!ap_rd || ap_a > `IOLT_STATUS_OFFSET |-> hrdata == 32'h0)
      else $error("hrdata nonzero outside a mapped read");
endmodule // iolt_line_props

// file: iolt_regs.vh
// register offsets, field layouts, reset values and timing counts for the control i/o line block
// assumes an ahb-lite slave with 32-bit data, one register per aligned word, 40 MHz hclk
//
// Notes on behaviour
// - direction 0 is input, 1 is output
// - source 0 disables line both ways
// - source 4 drives frame readout activity
// - source 6 drives exposure activity
// - source 10 follows the user output bit
// - source 18 drives the line pulse timer
// - invert setting 1 inverts, 0 passes
// - user output bit sets line low or high
// - input change accepted only after stable time
// - debounce time 0 to 1,000,000 microseconds
// - valid edge takes effect after debounce latency
// - timer trigger source off, frame or exposure
// - edge modes pulse for programmed duration
// - timer waits programmed delay before output
// - activation 0 falling edge, 1 rising edge
// - activation 2 level low, 3 level high
// - level mode output after delay while active
`ifndef IOLT_REGS_VH
`define IOLT_REGS_VH

`define IOLT_CTRL_OFFSET 12'h000
`define IOLT_USER_OFFSET 12'h004
`define IOLT_DEBOUNCE_OFFSET 12'h008
`define IOLT_TRIG_OFFSET 12'h00C
`define IOLT_DURATION_OFFSET 12'h010
`define IOLT_DELAY_OFFSET 12'h014
`define IOLT_STATUS_OFFSET 12'h018

// control register fields
`define IOLT_CTRL_DIR_BIT 0
`define IOLT_CTRL_INV_BIT 1
`define IOLT_CTRL_SRC_LSB 8
`define IOLT_CTRL_SRC_MSB 12
// trigger register fields
`define IOLT_TRIG_SRC_LSB 0
`define IOLT_TRIG_SRC_MSB 4
`define IOLT_TRIG_ACT_LSB 8
`define IOLT_TRIG_ACT_MSB 9
// status register fields
`define IOLT_STAT_IN_BIT 0
`define IOLT_STAT_LINE_BIT 1
`define IOLT_STAT_TIMER_BIT 2
`define IOLT_STAT_BUSY_BIT 3

// source and activation encodings
`define IOLT_SRC_OFF 5'h00
`define IOLT_SRC_FRAME 5'h04
`define IOLT_SRC_EXPOSURE 5'h06
`define IOLT_SRC_USER 5'h0A
`define IOLT_SRC_TIMER 5'h12
`define IOLT_ACT_FALL 2'h0
`define IOLT_ACT_RISE 2'h1
`define IOLT_ACT_LOW 2'h2
`define IOLT_ACT_HIGH 2'h3

// reset values
`define IOLT_CTRL_RESET 32'h0000_0000
`define IOLT_USER_RESET 1'h0
`define IOLT_DEBOUNCE_RESET 20'h0_0000
`define IOLT_TRIG_RESET 32'h0000_0000
`define IOLT_DURATION_RESET 26'h000_0001
`define IOLT_DELAY_RESET 26'h000_0000

// timing: hclk rate and the microsecond tick derived from it
`define IOLT_CLK_HZ 40000000
`define IOLT_US_PER_S 1000000
`define IOLT_CYC_PER_US (`IOLT_CLK_HZ / `IOLT_US_PER_S)
`define IOLT_DEBOUNCE_MAX_US 1000000
`define IOLT_TIMER_MAX_US 60000000

`endif

// file: tb_iolt_line.sv
// bench for the control i/o line: ahb-lite register tasks and pin checks
// assumes CYC_PER_US of 4, so one microsecond is four hclk cycles
`timescale 1ns/1ps
`include "iolt_regs.vh"
module tb_iolt_line;
   reg hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, frame_active = 0, exposure_active = 0;
   reg drv_en = 0, drv_val = 0;
   reg [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
   reg [1:0] htrans = 2'h0;
   reg [2:0] hsize = 3'h2;
   reg [4:0] tsel;
   reg [24:0] srcs = {5'h12, 5'h0A, 5'h06, 5'h04, 5'h00};
   wire hreadyout, hresp, line_out, line_oe, line_level, line_in;
   wire [31:0] hrdata;
   integer num_errors = 0, num_checks = 0, i, k, dly, wid;
   iolt_line #(.CYC_PER_US(4)) i_iolt_line (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .frame_active(frame_active),
      .exposure_active(exposure_active), .line_in(line_in), .line_out(line_out), .line_oe(line_oe),
      .line_level(line_level));
   iolt_ext_equip i_iolt_ext_equip (.hclk(hclk), .line_out(line_out), .line_oe(line_oe), .drv_en(drv_en),
      .drv_val(drv_val), .line_in(line_in));
   initial forever #12.5 hclk = ~hclk;
   task check(input string name, input [31:0] exp, input [31:0] got);
      begin
         num_checks = num_checks + 1;
         if (got !== exp)
         begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED %0s expected %0h seen %0h", name, exp, got);
         end
      end
   endtask
   task bus(input w, input [31:0] a, input [31:0] d);
      begin
         hsel <= 1'h1; haddr <= a; hwrite <= w; htrans <= 2'h2;
         @(posedge hclk);
         while (hreadyout !== 1'h1) @(posedge hclk);
         hsel <= 1'h0; htrans <= 2'h0; hwdata <= d;
         @(posedge hclk);
         while (hreadyout !== 1'h1) @(posedge hclk);
         rd = hrdata;
      end
   endtask
   task set_trg(input v);
      begin
         frame_active <= v ^ (tsel == `IOLT_SRC_EXPOSURE);
         exposure_active <= v ^ (tsel != `IOLT_SRC_EXPOSURE);
      end
   endtask
   // drive the trigger active for 40 cycles while measuring the pulse on line_out over 80 cycles
   task tcase(input [1:0] act, input [4:0] ts, input integer wlo, input integer whi);
      begin
         tsel = ts;
         bus(1, `IOLT_TRIG_OFFSET, {22'h0, act, 3'h0, ts});
         set_trg(!act[0]);
         repeat (20) @(posedge hclk);
         set_trg(act[0]);
         dly = 0; wid = 0;
         for (i = 0; i < 80; i = i + 1)
         begin
            @(posedge hclk);
            if (i == 40) set_trg(!act[0]);
            if (line_out === 1'h1) begin if (wid == 0) dly = i; wid = wid + 1; end
         end
         check("timer width", 1, wid >= wlo && wid <= whi);
         if (wlo > 0) check("timer delay", 1, dly >= 3 && dly <= 15);
      end
   endtask
   task report_and_stop;
      begin
         $display("checks %0d errors %0d", num_checks, num_errors);
         if (num_errors == 0 && num_checks > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   initial
   begin
      #500000;
      num_errors = num_errors + 1;
      report_and_stop;
   end
   initial
   begin
      repeat (3) @(posedge hclk);
      hresetn <= 1'h1;
      @(posedge hclk);
      bus(0, `IOLT_CTRL_OFFSET, 0); check("ctrl reset", `IOLT_CTRL_RESET, rd);
      bus(0, `IOLT_DURATION_OFFSET, 0); check("duration reset", 1, rd);
      bus(1, 32'h40, 32'hFFFF_FFFF); bus(0, 32'h40, 0); check("unmapped", 0, rd);
      bus(1, `IOLT_DEBOUNCE_OFFSET, 32'h00FF_FFFF); bus(0, `IOLT_DEBOUNCE_OFFSET, 0);
      check("debounce clamp", 1000000, rd);
      for (k = 0; k < 10; k = k + 1)
      begin
         bus(1, `IOLT_CTRL_OFFSET, {19'h0, srcs[5 * (k / 2) +: 5], 7'h0, k[0]});
         repeat (2) @(posedge hclk);
         check("line_oe", k[0] && k >= 2, line_oe);
      end
      for (k = 0; k < 4; k = k + 1)
      begin
         bus(1, `IOLT_CTRL_OFFSET, {19'h0, `IOLT_SRC_USER, 6'h0, k[1], 1'h1}); bus(1, `IOLT_USER_OFFSET, k[0]);
         repeat (2) @(posedge hclk);
         check("user out", k[0] ^ k[1], line_out);
      end
      for (k = 0; k < 8; k = k + 1)
      begin
         bus(1, `IOLT_CTRL_OFFSET, {19'h0, k[2] ? `IOLT_SRC_EXPOSURE : `IOLT_SRC_FRAME, 6'h0, k[1], 1'h1});
         frame_active <= k[0] ^ k[2]; exposure_active <= k[0] ^ !k[2];
         repeat (3) @(posedge hclk);
         check("activity out", k[0] ^ k[1], line_out);
      end
      bus(1, `IOLT_CTRL_OFFSET, {19'h0, `IOLT_SRC_TIMER, 8'h01});
      bus(1, `IOLT_DELAY_OFFSET, 2); bus(1, `IOLT_DURATION_OFFSET, 3);
      tcase(0, `IOLT_SRC_FRAME, 8, 17);
      tcase(1, `IOLT_SRC_EXPOSURE, 8, 17);
      tcase(3, `IOLT_SRC_EXPOSURE, 27, 37);
      tcase(2, `IOLT_SRC_FRAME, 27, 37);
      tcase(3, `IOLT_SRC_OFF, 0, 0);
      bus(1, `IOLT_CTRL_OFFSET, {19'h0, `IOLT_SRC_FRAME, 8'h00});
      bus(1, `IOLT_DEBOUNCE_OFFSET, 3);
      drv_en <= 1'h1; drv_val <= 1'h0; repeat (40) @(posedge hclk);
      drv_val <= 1'h1; repeat (6) @(posedge hclk); drv_val <= 1'h0; repeat (40) @(posedge hclk);
      check("glitch ignored", 0, line_level);
      drv_val <= 1'h1;
      for (dly = 0; dly < 100 && line_level !== 1'h1; dly = dly + 1) @(posedge hclk);
      check("debounce latency", 1, dly >= 15 && dly <= 24);
      bus(0, `IOLT_STATUS_OFFSET, 0); check("status", 32'h0000_0001, rd);
      report_and_stop;
   end
endmodule // tb_iolt_line
bind iolt_line iolt_line_props i_iolt_line_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
   .hresp(hresp), .hrdata(hrdata), .frame_active(frame_active), .exposure_active(exposure_active),
   .line_in(line_in), .line_out(line_out), .line_oe(line_oe), .line_level(line_level));
